// file: rtl/rsi_row_strobe_int.sv
// row-boundary strobe, interrupt and status flags.
// assumes op, sample ticks and memory events come from the device core,
// synchronous to I_SYS_CLK; select comes from the serial port pin.
`timescale 1ns/1ps
module rsi_row_strobe_int (
  input wire logic I_SYS_CLK,
  input wire logic I_SRST,
  input wire logic i_ce,
  input wire rsi_pkg::rsi_op_t i_op,
  input wire logic i_op_start,
  input wire logic i_sample_tick,
  input wire logic i_last_location,
  input wire logic i_marker_found,
  input wire logic [rsi_pkg::MARK_W-1:0] i_marker_pos,
  input wire logic [rsi_pkg::MARK_W-1:0] i_marker_sel,
  input wire logic i_ss_n,
  input wire logic i_read_status_instruction,
  output logic o_row_boundary_strobe_oe,
  output logic o_int_oe,
  output rsi_pkg::rsi_status_t o_status,
  output logic o_status_valid,
  output logic o_op_end
);
  import rsi_pkg::*;

  ////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {ST_IDLE, ST_PRELOAD, ST_HIGH, ST_LOW} rsi_st_t;

  rsi_st_t state;
  logic [CNT_W-1:0] cnt;
  logic ss_d;
  logic int_active;
  rsi_status_t status;
  logic status_valid;

  // record and playback both walk the array; cueing only skims it, so
  // reaching the last location while cueing is not an overflow
  function automatic logic moves_data(input rsi_op_t op);
    return (op == RSI_OP_RECORD) || (op == RSI_OP_PLAY);
  endfunction

  // one comparator per marker slot; only the selected slot ends playback
  logic [MARK_POSITIONS-1:0] mark_hit;
  for (genvar g = 0; g < MARK_POSITIONS; g++) begin : g_mark
    assign mark_hit[g] = i_marker_found && (i_marker_pos == MARK_W'(g)) &&
      (i_marker_sel == MARK_W'(g));
  end

  wire active = (i_op != RSI_OP_IDLE);
  wire cue = (i_op == RSI_OP_CUE);
  // cueing counts system clocks, other modes count sample ticks so the
  // timing follows whatever sample rate the core runs at
  wire step = cue ? 1'b1 : i_sample_tick;
  wire [CNT_W-1:0] high_len = cue ? CUE_HIGH_CYC[CNT_W-1:0] : ROW_HIGH_SAMPLES[CNT_W-1:0];
  wire [CNT_W-1:0] low_len = cue ? CUE_LOW_CYC[CNT_W-1:0] : ROW_LOW_SAMPLES[CNT_W-1:0];
  wire cnt_done = step && (cnt == CNT_ONE);
  wire ss_fall = ss_d && !i_ss_n;
  wire ovf_evt = moves_data(i_op) && i_last_location;
  wire eom_evt = (i_op == RSI_OP_PLAY) && (|mark_hit);
  wire term_evt = ovf_evt || eom_evt;

  ////////////////////////////////////////////////////////////////
  rsi_st_t next_state;
  logic [CNT_W-1:0] next_cnt;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    if (!active) begin
      next_state = ST_IDLE;
      next_cnt = CNT_ZERO;
    end else if (i_op_start || state == ST_IDLE) begin
      // record needs an extra high stretch while sample-and-hold loads
      if (i_op == RSI_OP_RECORD) begin
        next_state = ST_PRELOAD;
        next_cnt = low_len;
      end else begin
        next_state = ST_HIGH;
        next_cnt = high_len;
      end
    end else if (step) begin
      if (cnt_done) begin
        case (state)
          ST_PRELOAD: begin
            next_state = ST_HIGH;
            next_cnt = high_len;
          end
          ST_HIGH: begin
            next_state = ST_LOW;
            next_cnt = low_len;
          end
          default: begin
            next_state = ST_HIGH;
            next_cnt = high_len;
          end
        endcase
      end else begin
        next_cnt = cnt - CNT_ONE;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      state <= ST_IDLE;
      cnt <= CNT_ZERO;
    end else if (i_ce) begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // open drain: pulling low only in the low phase of a row
  assign o_row_boundary_strobe_oe = (state == ST_LOW);

  ////////////////////////////////////////////////////////////////
  // check-only helpers: steps spent in the current strobe phase and the
  // length of the last high phase, so whole-row timing can be held
  // without a long consecutive repetition in the properties
  localparam logic [CNT_W-1:0] ROW_HIGH_LAST = CNT_W'(ROW_HIGH_SAMPLES - 1);
  localparam logic [CNT_W-1:0] ROW_LOW_LAST = CNT_W'(ROW_LOW_SAMPLES - 1);
  localparam logic [CNT_W-1:0] CUE_LOW_LAST = CNT_W'(CUE_LOW_CYC - 1);
  localparam logic [CNT_W-1:0] ROW_SPAN_LAST = CNT_W'(ROW_SAMPLES - 2);

  logic [CNT_W-1:0] phase_steps;
  logic [CNT_W-1:0] high_steps;
  // a restart or a phase change starts the count again
  wire phase_restart = (next_state != state) || i_op_start || !active;

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      phase_steps <= CNT_ZERO;
      high_steps <= CNT_ZERO;
    end else if (i_ce) begin
      if (phase_restart) begin
        phase_steps <= CNT_ZERO;
      end else if (step) begin
        phase_steps <= phase_steps + CNT_ONE;
      end
      if (state == ST_HIGH && next_state == ST_LOW) begin
        high_steps <= phase_steps;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // flags and interrupt; a new terminating event wins over a clear
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      ss_d <= 1'b1;
      int_active <= 1'b0;
      status <= '0;
      status_valid <= 1'b0;
      o_op_end <= 1'b0;
    end else if (i_ce) begin
      ss_d <= i_ss_n;
      o_op_end <= term_evt;
      if (term_evt) begin
        int_active <= 1'b1;
      end else if (ss_fall) begin
        int_active <= 1'b0;
      end
      if (term_evt) begin
        status.overflow <= status.overflow | ovf_evt;
        status.end_of_message <= status.end_of_message | eom_evt;
      end else if (ss_fall) begin
        status <= '0;
      end
      status_valid <= i_read_status_instruction;
    end
  end

  assign o_int_oe = int_active;
  always_comb begin
    o_status = status;
    o_status_valid = status_valid;
  end

  ////////////////////////////////////////////////////////////////
  sequence s_term;
    i_ce && term_evt;
  endsequence

  property p_int_set;
    @(posedge I_SYS_CLK) disable iff (I_SRST) s_term |=> o_int_oe;
  endproperty
  a_int_set: assert property (p_int_set) else $error("interrupt not raised");

  property p_int_hold;
    @(posedge I_SYS_CLK) disable iff (I_SRST)
      (o_int_oe && i_ss_n && !(i_ce && ss_fall)) |=> o_int_oe;
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("interrupt dropped early");

  property p_int_each;
    @(posedge I_SYS_CLK) disable iff (I_SRST)
      (i_ce && ss_fall && term_evt) |=> o_int_oe;
  endproperty
  a_int_each: assert property (p_int_each) else $error("event lost at clear");

  property p_int_clr;
    @(posedge I_SYS_CLK) disable iff (I_SRST)
      (i_ce && ss_fall && !term_evt) |=> !o_int_oe;
  endproperty
  a_int_clr: assert property (p_int_clr) else $error("interrupt not cleared");

  property p_ovf;
    @(posedge I_SYS_CLK) disable iff (I_SRST) (i_ce && ovf_evt) |=> o_status.overflow;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag missing");

  property p_eom_rec;
    @(posedge I_SYS_CLK) disable iff (I_SRST)
      (i_ce && i_op == RSI_OP_RECORD && !o_status.end_of_message)
        |=> !o_status.end_of_message;
  endproperty
  a_eom_rec: assert property (p_eom_rec) else $error("eom set in record");

  property p_status;
    @(posedge I_SYS_CLK) disable iff (I_SRST)
      (i_ce && i_read_status_instruction) |=> o_status_valid;
  endproperty
  a_status: assert property (p_status) else $error("status not reported");

  property p_low_len;
    @(posedge I_SYS_CLK) disable iff (I_SRST)
      (i_ce && state == ST_HIGH && next_state == ST_LOW && !cue && active)
        |=> cnt == ROW_LOW_SAMPLES[CNT_W-1:0];
  endproperty
  a_low_len: assert property (p_low_len) else $error("row low length wrong");

  property p_cue_high;
    @(posedge I_SYS_CLK) disable iff (I_SRST)
      (i_ce && cue && state == ST_LOW && next_state == ST_HIGH && !i_op_start)
        |=> cnt == CUE_HIGH_CYC[CNT_W-1:0];
  endproperty
  a_cue_high: assert property (p_cue_high) else $error("cue high length wrong");

  property p_preload;
    @(posedge I_SYS_CLK) disable iff (I_SRST)
      (i_ce && i_op_start && i_op == RSI_OP_RECORD) |=> state == ST_PRELOAD;
  endproperty
  a_preload: assert property (p_preload) else $error("record preload missing");

  ////////////////////////////////////////////////////////////////
  // phase lengths, counted in steps by the helpers above
  sequence s_row_turn;
    i_ce && !cue && state == ST_LOW && next_state == ST_HIGH && !i_op_start;
  endsequence

  property p_row_high;
    @(posedge I_SYS_CLK) disable iff (I_SRST)
      (i_ce && !cue && state == ST_HIGH && next_state == ST_LOW) |-> phase_steps == ROW_HIGH_LAST;
  endproperty
  a_row_high: assert property (p_row_high) else $error("row high length wrong");

  property p_row_period;
    @(posedge I_SYS_CLK) disable iff (I_SRST)
      s_row_turn |-> (high_steps + phase_steps) == ROW_SPAN_LAST;
  endproperty
  a_row_period: assert property (p_row_period) else $error("row period wrong");

  property p_preload_len;
    @(posedge I_SYS_CLK) disable iff (I_SRST)
      (i_ce && state == ST_PRELOAD && next_state == ST_HIGH && !i_op_start)
        |-> phase_steps == ROW_LOW_LAST;
  endproperty
  a_preload_len: assert property (p_preload_len) else $error("preload length wrong");

  property p_cue_low;
    @(posedge I_SYS_CLK) disable iff (I_SRST)
      (i_ce && cue && state == ST_LOW && next_state == ST_HIGH && !i_op_start)
        |-> phase_steps == CUE_LOW_LAST;
  endproperty
  a_cue_low: assert property (p_cue_low) else $error("cue low length wrong");

  // outside cueing, without a sample tick the strobe must not move, whatever the rate
  property p_tick_pace;
    @(posedge I_SYS_CLK) disable iff (I_SRST)
      (i_ce && active && !cue && !i_sample_tick && !i_op_start && state != ST_IDLE)
        |=> $stable(state) && $stable(cnt);
  endproperty
  a_tick_pace: assert property (p_tick_pace) else $error("strobe moved without tick");

  property p_idle_release;
    @(posedge I_SYS_CLK) disable iff (I_SRST)
      (i_ce && !active) |=> !o_row_boundary_strobe_oe;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("strobe held when idle");

  ////////////////////////////////////////////////////////////////
  // end-of-operation pulse and marker selection
  property p_op_end;
    @(posedge I_SYS_CLK) disable iff (I_SRST) s_term |=> o_op_end;
  endproperty
  a_op_end: assert property (p_op_end) else $error("operation end missing");

  property p_mark_pos;
    @(posedge I_SYS_CLK) disable iff (I_SRST)
      (i_ce && i_marker_found && i_marker_pos != i_marker_sel && !ovf_evt) |=> !o_op_end;
  endproperty
  a_mark_pos: assert property (p_mark_pos) else $error("wrong marker slot taken");

  property p_quiet_op;
    @(posedge I_SYS_CLK) disable iff (I_SRST)
      (i_ce && !moves_data(i_op)) |=> !o_op_end;
  endproperty
  a_quiet_op: assert property (p_quiet_op) else $error("end without transfer");
endmodule

// file: rtl/rsi_pkg.sv
// package: constants and types for the row strobe and interrupt block.
// assumes a 100 MHz system clock and a sample tick input at the sample rate.
package rsi_pkg;
  // samples per row at any rate: 200 ms * 8 kHz
  localparam int ROW_SAMPLES = 1600;
  localparam int ROW_HIGH_SAMPLES = 1400;
  localparam int ROW_LOW_SAMPLES = 200;
  // cueing times in ns; converted to system clocks at 100 MHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int CUE_HIGH_NS = 109370;
  localparam int CUE_LOW_NS = 15630;
  localparam int CUE_HIGH_CYC = (CUE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CUE_LOW_CYC = (CUE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  localparam int MARK_POSITIONS = 8;
  localparam int MARK_W = 3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  typedef enum logic [1:0] {
    RSI_OP_IDLE,
    RSI_OP_RECORD,
    RSI_OP_PLAY,
    RSI_OP_CUE
  } rsi_op_t;

  typedef struct packed {
    logic overflow;
    logic end_of_message;
  } rsi_status_t;
endpackage

// file: verification/rsi_host_model.sv
// host side model: drives slave select and the read-status request.
// assumes the bench calls its tasks; pins change on the falling clock edge.
`timescale 1ns/1ps
module rsi_host_model (
  input wire logic I_SYS_CLK,
  output logic o_ss_n,
  output logic o_rd
);
  initial begin
    o_ss_n = 1'b1;
    o_rd = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // select falls to open a cycle, held low a few clocks
  task automatic cycle();
    @(negedge I_SYS_CLK) o_ss_n = 1'b0;
    repeat (3) @(negedge I_SYS_CLK);
    o_ss_n = 1'b1;
  endtask
  // status read is one instruction inside a fresh cycle
  task automatic poll();
    @(negedge I_SYS_CLK) o_ss_n = 1'b0;
    o_rd = 1'b1;
    @(negedge I_SYS_CLK) o_rd = 1'b0;
    repeat (2) @(negedge I_SYS_CLK);
    o_ss_n = 1'b1;
  endtask
endmodule

// file: verification/tb.sv
// testbench for the row strobe and interrupt block.
// assumes ticks every two clocks; host model drives select and polling.
`timescale 1ns/1ps
module tb;
  import rsi_pkg::*;
  logic clk = 1'b0, rst = 1'b1, start = 1'b0, tick = 1'b0, last = 1'b0, mark = 1'b0;
  logic [2:0] pos = 3'h0, sel = 3'h5;
  rsi_op_t op = RSI_OP_IDLE;
  logic ss_n, rd, rac_oe, int_oe, st_v, op_end;
  rsi_status_t st;
  int bad_count = 0, comparisons = 0;
  initial forever #5 clk = ~clk;
  rsi_host_model host (.I_SYS_CLK(clk), .o_ss_n(ss_n), .o_rd(rd));
  rsi_row_strobe_int DUT (.I_SYS_CLK(clk), .I_SRST(rst), .i_ce(1'b1), .i_op(op),
    .i_op_start(start), .i_sample_tick(tick), .i_last_location(last),
    .i_marker_found(mark), .i_marker_pos(pos), .i_marker_sel(sel), .i_ss_n(ss_n),
    .i_read_status_instruction(rd), .o_row_boundary_strobe_oe(rac_oe),
    .o_int_oe(int_oe), .o_status(st), .o_status_valid(st_v), .o_op_end(op_end));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [2:0] g, input logic [2:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %b expected %b", $time, g, e);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) begin
      @(negedge clk) tick = 1'b1;
      @(negedge clk) tick = 1'b0;
    end
  endtask
  task automatic go(input rsi_op_t o);
    @(negedge clk) op = RSI_OP_IDLE;
    repeat (3) @(negedge clk);
    op = o;
    start = 1'b1;
    @(negedge clk) start = 1'b0;
  endtask
  // one event pulse, judged in the cycle after it is taken
  task automatic ev(input logic l, input logic m, input logic [2:0] p);
    @(negedge clk) last = l;
    mark = m;
    pos = p;
    @(negedge clk) last = 1'b0;
    mark = 1'b0;
  endtask
  task print_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_row();
    go(RSI_OP_PLAY);
    tk(1398); chk(rac_oe, 0);
    tk(4); chk(rac_oe, 1);
    tk(196); chk(rac_oe, 1);
    tk(4); chk(rac_oe, 0);
  endtask
  task automatic t_rec();
    go(RSI_OP_RECORD);
    tk(1598); chk(rac_oe, 0);
    tk(4); chk(rac_oe, 1);
  endtask
  task automatic t_cue();
    go(RSI_OP_CUE);
    repeat (10930) @(negedge clk);
    chk(rac_oe, 0);
    repeat (15) @(negedge clk);
    chk(rac_oe, 1);
    repeat (1550) @(negedge clk);
    chk(rac_oe, 1);
    repeat (15) @(negedge clk);
    chk(rac_oe, 0);
  endtask
  task automatic t_flags();
    go(RSI_OP_PLAY);
    ev(1, 0, 0); chk({int_oe, op_end}, 2'b11); chk(st, 2'b10);
    repeat (4) @(negedge clk);
    chk(int_oe, 1);
    host.cycle(); chk({int_oe, st}, 3'b000);
    ev(0, 1, 3'h4); chk(int_oe, 0);
    ev(0, 1, 3'h5); chk(int_oe, 1); chk(st, 2'b01);
    host.poll(); chk(int_oe, 0);
    go(RSI_OP_RECORD);
    ev(0, 1, 3'h5); chk(int_oe, 0);
    ev(1, 0, 0); chk(int_oe, 1); chk(st, 2'b10);
    host.cycle(); ev(1, 0, 0); chk(int_oe, 1);
    host.cycle(); chk(int_oe, 0);
    fork
      host.cycle();
      ev(1, 0, 0);
    join
    chk(int_oe, 1);
  endtask
  task automatic t_reset();
    go(RSI_OP_PLAY);
    ev(1, 0, 0);
    @(negedge clk) rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk({int_oe, st}, 3'h0);
    tk(2); chk({rac_oe, op_end}, 2'h0);
  endtask
  task automatic t_poll();
    @(negedge clk) op = RSI_OP_IDLE;
    fork
      host.poll();
      begin
        @(negedge clk) @(negedge clk) chk(st_v, 1);
        @(negedge clk) chk({st_v, rac_oe}, 0);
      end
    join
  endtask
  initial begin
    #400000;
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    chk({int_oe, rac_oe}, 0);
    t_row();
    t_rec();
    t_cue();
    t_flags();
    t_reset();
    t_poll();
    print_verdict();
  end
endmodule
